// [common/ifp_pkg.sv]
// constants for the inverter fault protection block
package ifp_pkg;
  localparam int unsigned CLK_FREQ_HZ = 40_000_000;
  localparam int unsigned NUM_PHASES = 3;
  // fault pulse minimum, microseconds
  localparam int unsigned FAULT_PULSE_MIN_TIME_US = 20;
  // least time: whole cycles, no rounding
  localparam int unsigned FAULT_PULSE_CYCLES =
    (FAULT_PULSE_MIN_TIME_US * (CLK_FREQ_HZ / 1_000_000));
  // minimum input pulse width, nanoseconds
  localparam int unsigned MIN_PULSE_NS = 700;
  localparam int unsigned MIN_PULSE_CYCLES_RAW = (MIN_PULSE_NS * (CLK_FREQ_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned MIN_PULSE_CYCLES = (MIN_PULSE_CYCLES_RAW < 1) ? 1 : MIN_PULSE_CYCLES_RAW;
  localparam int unsigned FAULT_CNT_W = 10;
  localparam int unsigned PULSE_CNT_W = 5;
  localparam logic [FAULT_CNT_W-1:0] FAULT_CNT_LOAD = FAULT_CNT_W'(FAULT_PULSE_CYCLES - 1);
  localparam logic [PULSE_CNT_W-1:0] PULSE_CNT_LOAD = PULSE_CNT_W'(MIN_PULSE_CYCLES - 1);
  localparam logic [PULSE_CNT_W-1:0] PULSE_CNT_ZERO = 5'h00;
  localparam logic [FAULT_CNT_W-1:0] FAULT_CNT_ZERO = 10'h000;
  localparam logic [NUM_PHASES-1:0] PHASES_OFF = 3'h0;
  localparam logic [NUM_PHASES-1:0] PHASES_ON = 3'h7;
  typedef enum logic [1:0] {
    IFP_RUN,
    IFP_SC_PULSE,
    IFP_HOLD
  } ifp_state_t;
endpackage

// [src/ifp_pulse_filter.sv]
// input deglitch: passes a level only after it has been stable for the minimum pulse width
module ifp_pulse_filter
  import ifp_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic raw_in,
  output logic filtered
);
  logic [PULSE_CNT_W-1:0] count;
  logic [PULSE_CNT_W-1:0] next_count;
  logic next_filtered;

  always_comb begin
    next_count = count;
    next_filtered = filtered;
    if (raw_in == filtered) begin
      next_count = PULSE_CNT_LOAD;
    end else if (count == PULSE_CNT_ZERO) begin
      next_filtered = raw_in;
      next_count = PULSE_CNT_LOAD;
    end else begin
      next_count = count - 5'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      count <= PULSE_CNT_LOAD;
      filtered <= 1'b0;
    end else begin
      count <= next_count;
      filtered <= next_filtered;
    end
  end
endmodule

// [src/ifp_protect.sv]
// low-side protection and gate gating for a three-phase inverter module
//
// What this block does
// - comparator trip on current sense is a short-circuit event, handled in hardware.
// - short circuit turns all three low-side gates off and asserts fault together.
// - short-circuit path acts on low-side gates only, never high-side.
// - after short circuit the fault output holds at least 20 us, then releases.
// - after fault ends each low-side phase re-arms on its own rising input.
// - pulses shorter than 0.7 us may be ignored; controller avoids them.
// - undervoltage or overtemperature holds fault while present, at least 20 us.
// - low-side undervoltage forces all low-side gates off whatever the inputs.
module ifp_protect
  import ifp_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic current_sense_in,
  input wire logic supply_undervoltage,
  input wire logic overtemperature,
  input wire logic [ifp_pkg::NUM_PHASES-1:0] low_side_in,
  input wire logic [ifp_pkg::NUM_PHASES-1:0] high_side_in,
  output logic [ifp_pkg::NUM_PHASES-1:0] low_side_gate,
  output logic [ifp_pkg::NUM_PHASES-1:0] high_side_gate,
  output logic fault_out_n,
  output logic short_circuit_trip
);
  ////////////////////////////////////////////////////////////////////////////
  logic [NUM_PHASES-1:0] low_filt;
  logic [NUM_PHASES-1:0] high_filt;
  logic [NUM_PHASES-1:0] low_prev;
  logic [NUM_PHASES-1:0] next_low_prev;

  // one filter per input; a glitch shorter than the minimum pulse never reaches a gate
  genvar g;
  generate
    for (g = 0; g < NUM_PHASES; g++) begin : g_phase
      ifp_pulse_filter u_low_filt (
        .clk(clk),
        .sys_rst(sys_rst),
        .raw_in(low_side_in[g]),
        .filtered(low_filt[g])
      );
      ifp_pulse_filter u_high_filt (
        .clk(clk),
        .sys_rst(sys_rst),
        .raw_in(high_side_in[g]),
        .filtered(high_filt[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  ifp_state_t state;
  ifp_state_t next_state;
  logic [FAULT_CNT_W-1:0] fault_cnt;
  logic [FAULT_CNT_W-1:0] next_fault_cnt;
  logic [NUM_PHASES-1:0] armed;
  logic [NUM_PHASES-1:0] next_armed;
  logic next_fault_out_n;
  logic next_short_circuit_trip;
  logic [NUM_PHASES-1:0] next_low_side_gate;
  logic [NUM_PHASES-1:0] next_high_side_gate;
  logic slow_fault;
  logic [NUM_PHASES-1:0] rise;

  assign slow_fault = supply_undervoltage | overtemperature;
  assign rise = low_filt & ~low_prev;

  always_comb begin
    next_state = state;
    next_fault_cnt = fault_cnt;
    next_armed = armed;
    next_low_prev = low_filt;
    next_short_circuit_trip = 1'b0;
    case (state)
      IFP_RUN: begin
        // re-arm each phase on its own rising edge
        next_armed = armed | rise;
        if (current_sense_in) begin
          next_state = IFP_SC_PULSE;
          next_fault_cnt = FAULT_CNT_LOAD;
          next_armed = PHASES_OFF;
          next_short_circuit_trip = 1'b1;
        end else if (supply_undervoltage) begin
          next_state = IFP_HOLD;
          next_fault_cnt = FAULT_CNT_LOAD;
          next_armed = PHASES_OFF;
        end else if (overtemperature) begin
          next_state = IFP_HOLD;
          next_fault_cnt = FAULT_CNT_LOAD;
          next_armed = PHASES_OFF;
        end
      end
      IFP_SC_PULSE: begin
        next_armed = PHASES_OFF;
        // fixed width regardless of the comparator afterwards
        if (fault_cnt != FAULT_CNT_ZERO) begin
          next_fault_cnt = fault_cnt - 10'h001;
        end else if (slow_fault) begin
          next_state = IFP_HOLD;
        end else begin
          next_state = IFP_RUN;
        end
      end
      IFP_HOLD: begin
        next_armed = PHASES_OFF;
        if (fault_cnt != FAULT_CNT_ZERO) begin
          next_fault_cnt = fault_cnt - 10'h001;
        end else if (!slow_fault) begin
          next_state = IFP_RUN;
        end
      end
      default: begin
        next_state = IFP_RUN;
        next_armed = PHASES_OFF;
      end
    endcase
  end

  always_comb begin
    // fault low while any fault state is next; high otherwise
    next_fault_out_n = (next_state == IFP_RUN);
    // low side gated by arming and by undervoltage directly
    next_low_side_gate = (next_state == IFP_RUN && !supply_undervoltage) ?
      (low_filt & next_armed) : PHASES_OFF;
    // high side untouched by the short-circuit path
    next_high_side_gate = high_filt;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state <= IFP_RUN;
      fault_cnt <= FAULT_CNT_ZERO;
      armed <= PHASES_OFF;
      low_prev <= PHASES_ON;
      fault_out_n <= 1'b1;
      short_circuit_trip <= 1'b0;
      low_side_gate <= PHASES_OFF;
      high_side_gate <= PHASES_OFF;
    end else begin
      state <= next_state;
      fault_cnt <= next_fault_cnt;
      armed <= next_armed;
      low_prev <= next_low_prev;
      fault_out_n <= next_fault_out_n;
      short_circuit_trip <= next_short_circuit_trip;
      low_side_gate <= next_low_side_gate;
      high_side_gate <= next_high_side_gate;
    end
  end
endmodule

// [bench/ifp_ctrl_model.sv]
// pwm controller model: three legs at 20 kHz, 1 us dead time before low on and 2 us before high on
module ifp_ctrl_model (
  input wire logic clk,
  input wire logic run,
  output logic [2:0] lo = 3'h0,
  output logic [2:0] hi = 3'h0
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [10:0] cnt = 11'h000;
  always @(posedge clk) begin
    cnt <= (!run || cnt == 11'h7CF) ? 11'h000 : cnt + 11'h001;
    hi <= {3{run && cnt >= 11'h028 && cnt < 11'h3C0}};
    lo <= {3{run && cnt >= 11'h3E8 && cnt < 11'h7A8}};
  end
endmodule

// [bench/ifp_protect_asserts.sv]
// port checker for the protection block
module ifp_protect_chk
  import ifp_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic current_sense_in,
  input wire logic supply_undervoltage,
  input wire logic overtemperature,
  input wire logic [ifp_pkg::NUM_PHASES-1:0] low_side_in,
  input wire logic [ifp_pkg::NUM_PHASES-1:0] high_side_in,
  input wire logic [ifp_pkg::NUM_PHASES-1:0] low_side_gate,
  input wire logic [ifp_pkg::NUM_PHASES-1:0] high_side_gate,
  input wire logic fault_out_n,
  input wire logic short_circuit_trip
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [11:0] low_cnt, next_low_cnt;
  logic [2:0] seen_low, next_seen_low;
  // a phase may drive only once its input was low after the fault
  always_comb begin
    next_low_cnt = fault_out_n ? 12'h000 : low_cnt + 12'h001;
    next_seen_low = fault_out_n ? (seen_low | ~low_side_in) : 3'h0;
  end
  always_ff @(posedge clk) begin
    low_cnt <= sys_rst ? 12'h000 : next_low_cnt;
    seen_low <= sys_rst ? 3'h0 : next_seen_low;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  AST_SC_TAKEN: assert property (current_sense_in && fault_out_n |=> short_circuit_trip)
    else $error("trip not taken");
  AST_SC_OFF: assert property (short_circuit_trip |-> !fault_out_n && low_side_gate == 3'h0)
    else $error("trip without shutdown");
  AST_HIGH_KEEP: assert property (((high_side_gate ^ $past(high_side_gate))
    & (high_side_gate ^ $past(high_side_in))) == 3'h0) else $error("high gate moved");
  AST_FAULT_MIN: assert property ($rose(fault_out_n) |-> low_cnt >= 12'h320)
    else $error("fault pulse short");
  AST_HOLD_CAUSE: assert property (!fault_out_n && low_cnt >= 12'h322
    |-> $past(supply_undervoltage) || $past(overtemperature)) else $error("fault held");
  AST_UV_OT_FAULT: assert property (supply_undervoltage || overtemperature |=> !fault_out_n)
    else $error("no fault");
  AST_UV_GATES: assert property (supply_undervoltage |=> low_side_gate == 3'h0)
    else $error("uv gate on");
  AST_FAULT_GATES: assert property (!fault_out_n |-> low_side_gate == 3'h0)
    else $error("gate on in fault");
  AST_REARM: assert property ((low_side_gate & ~seen_low) == 3'h0)
    else $error("rearm without edge");
endmodule
bind ifp_protect ifp_protect_chk ifp_protect_chk_i (.clk(clk), .sys_rst(sys_rst),
  .current_sense_in(current_sense_in), .supply_undervoltage(supply_undervoltage),
  .overtemperature(overtemperature), .low_side_in(low_side_in), .high_side_in(high_side_in),
  .low_side_gate(low_side_gate), .high_side_gate(high_side_gate), .fault_out_n(fault_out_n),
  .short_circuit_trip(short_circuit_trip));

// [bench/tb.sv]
// testbench: random fault timing against the controller model
module tb;
  import ifp_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic current_sense_in = 1'b0;
  logic supply_undervoltage = 1'b0;
  logic overtemperature = 1'b0;
  logic run = 1'b0;
  logic [2:0] lo, hi, lg, hg;
  logic fault_out_n, short_circuit_trip;
  logic [31:0] rs = 32'h00000063;
  int n_fail = 0, checks_done = 0, w;
  always #12.5 clk = ~clk;
  ifp_ctrl_model ifp_ctrl_model_i (.clk(clk), .run(run), .lo(lo), .hi(hi));
  ifp_protect ifp_protect_i (.clk(clk), .sys_rst(sys_rst), .current_sense_in(current_sense_in),
    .supply_undervoltage(supply_undervoltage), .overtemperature(overtemperature), .low_side_in(lo),
    .high_side_in(hi), .low_side_gate(lg), .high_side_gate(hg), .fault_out_n(fault_out_n),
    .short_circuit_trip(short_circuit_trip));
  function automatic logic [31:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction
  task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic at_cnt(int c);
    do @(posedge clk); while (ifp_ctrl_model_i.cnt != c);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    run <= 1'b1;
    at_cnt(500);
    @(negedge clk);
    chk("high gates", {hg, lg}, 6'h38);
    at_cnt(1500);
    @(negedge clk);
    chk("gates", {hg, lg}, 6'h07);
    $display("normal test done");
    at_cnt(1100 + rnd() % 40);
    current_sense_in <= 1'b1;
    @(posedge clk);
    current_sense_in <= 1'b0;
    @(negedge clk);
    chk("trip", {short_circuit_trip, fault_out_n, lg}, 5'h10);
    w = 0;
    while (fault_out_n === 1'b0 && w < 2000) begin
      w++;
      @(negedge clk);
    end
    chk("fault width", w >= FAULT_PULSE_CYCLES && w <= FAULT_PULSE_CYCLES + 1, 1'b1);
    at_cnt(1955);
    @(negedge clk);
    chk("held input no rearm", lg, 3'h0);
    at_cnt(1500);
    @(negedge clk);
    chk("rearmed", lg, 3'h7);
    $display("short circuit test done");
    // fault starts mid low-input half and ends in the next high-input half; release lands before the next rise
    for (int k = 0; k < 2; k++) begin
      at_cnt(1500);
      {overtemperature, supply_undervoltage} <= (k == 0) ? 2'h1 : 2'h2;
      repeat (900 + rnd() % 600) @(posedge clk);
      {overtemperature, supply_undervoltage} <= 2'h0;
      @(negedge clk);
      chk("fault held", {fault_out_n, lg}, 4'h0);
      @(negedge clk);
      chk("fault released", fault_out_n, 1'b1);
    end
    $display("supply and temperature test done");
    close_out();
  end
  initial begin
    repeat (30000) @(posedge clk);
    n_fail++;
    $display("Error watchdog expected done seen hang");
    close_out();
  end
endmodule
